// file: design/sfcg_gate.sv
// Command acceptance and configuration gating of the serial flash.
//
// Contract
// - Latency code bits 7:6 set read cycles.
// - Quad program and reads need quad enable.
// - DDR quad read also needs quad enable.
// - Quad enable bit resets to one.
// - Powered off: no response, no program.
// - No command before power-on reset ends.
// - Below cut-off supply, commands are discarded.
// - Writes need clock count multiple of eight.
// - Instructions ignored until power-up delay ends.
// - After delay: standby, latch cleared.
// - Hardware or soft reset restarts power-up.
// - Instruction captured MSB first, rising edges.
`timescale 1ns/10ps
`default_nettype none
module sfcg_gate #(
    parameter int PU_CYCLES = sfcg_pkg::POWER_UP_DELAY_CYC
) (
    // System clock and control
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // Serial link
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    // Supply monitor and hardware reset pins
    input wire logic vcc_above_min,
    input wire logic vcc_above_cutoff,
    input wire logic hw_reset_n,
    // Configuration write port
    input wire logic cfg_wr,
    input wire logic [7:0] cfg_data,
    // Status
    output logic ready,
    output logic [7:0] configuration_register_one,
    output logic write_enable_latch,
    output logic deep_power_down,
    // Accepted command
    output logic cmd_valid,
    output logic [7:0] cmd_opcode,
    output sfcg_pkg::sfcg_kind_type cmd_kind,
    output logic [3:0] cmd_mode_cycles,
    output logic [3:0] cmd_dummy_cycles
);
    import sfcg_pkg::*;

    localparam int CW = $clog2(PU_CYCLES + 1);
    localparam logic [CW-1:0] PU_LAST = CW'(PU_CYCLES - 1);

    // ------------------------------------------------------------
    // Link domain
    // ------------------------------------------------------------
    logic [7:0] link_opcode;
    logic link_full;
    logic [2:0] link_mod;
    logic link_tog;

    sfcg_link u_link (
        .sck(sck),
        .rst_n(rst_n),
        .cs_n(cs_n),
        .si(si),
        .opcode(link_opcode),
        .opcode_full(link_full),
        .pulse_mod(link_mod),
        .frame_tog(link_tog)
    );

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [4:0] pins_sync;
    logic cs_hi_s;
    logic pwr_s;
    logic cutoff_s;
    logic hwrst_n_s;
    logic tog_s;

    sfcg_sync #(
        .WIDTH(5),
        .INIT(5'h0D)
    ) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .async_in({link_tog, hw_reset_n, vcc_above_cutoff, vcc_above_min, cs_n}),
        .sync_out(pins_sync)
    );

    assign cs_hi_s = pins_sync[0];
    assign pwr_s = pins_sync[1];
    assign cutoff_s = pins_sync[2];
    assign hwrst_n_s = pins_sync[3];
    assign tog_s = pins_sync[4];

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        sfcg_pwr_type pwr;
        logic [CW-1:0] cnt;
        logic tog_seen;
        logic [7:0] cfg1;
        logic wlat;
        logic dpd;
        logic valid;
        logic [7:0] opc;
        sfcg_kind_type kind;
        logic [3:0] mode;
        logic [3:0] dummy;
    } sfcg_gate_type;

    sfcg_gate_type st_reg;
    sfcg_gate_type st_next;

    logic frame_done;
    logic accepting;
    logic quad_en;
    logic [1:0] lat_code;
    logic byte_ok;

    assign frame_done = cs_hi_s && (tog_s != st_reg.tog_seen);
    assign quad_en = st_reg.cfg1[CFG1_QUAD_BIT];
    assign lat_code = st_reg.cfg1[CFG1_LAT_MSB:CFG1_LAT_LSB];
    assign byte_ok = (link_mod == BYTE_MOD_ZERO);

    // Commands are taken only in standby with a healthy supply.
    always_comb begin
        accepting = 1'b1;
        if (!pwr_s) begin
            accepting = 1'b0;
        end
        if (st_reg.pwr != PWR_STANDBY) begin
            accepting = 1'b0;
        end
        if (!cutoff_s) begin
            accepting = 1'b0;
        end
        if (!link_full) begin
            accepting = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.valid = 1'b0;
        if (frame_done) begin
            st_next.tog_seen = tog_s;
        end
        if (cfg_wr && pwr_s) begin
            st_next.cfg1 = cfg_data;
        end
        unique case (st_reg.pwr)
            PWR_OFF: begin
                st_next.wlat = 1'b0;
                st_next.dpd = 1'b0;
                st_next.cnt = '0;
                if (pwr_s) begin
                    st_next.pwr = PWR_STARTUP;
                end
            end
            PWR_STARTUP: begin
                if (st_reg.cnt == PU_LAST) begin
                    st_next.pwr = PWR_STANDBY;
                    st_next.wlat = 1'b0;
                    st_next.dpd = 1'b0;
                end else begin
                    st_next.cnt = st_reg.cnt + CW'(1);
                end
            end
            PWR_STANDBY: begin
                if (frame_done && accepting) begin
                    if (st_reg.dpd) begin
                        if (link_opcode == OP_RELEASE_POWER_DOWN) begin
                            st_next.dpd = 1'b0;
                        end
                    end else begin
                        st_next.opc = link_opcode;
                        st_next.mode = 4'h0;
                        st_next.dummy = 4'h0;
                        unique case (link_opcode)
                            OP_READ: begin
                                st_next.valid = 1'b1;
                                st_next.kind = KIND_READ;
                            end
                            OP_FAST_READ: begin
                                st_next.valid = 1'b1;
                                st_next.kind = KIND_READ;
                                st_next.dummy = DUMMY_FAST_TAB[lat_code*4 +: 4];
                            end
                            OP_QUAD_OUT_READ: begin
                                st_next.valid = quad_en;
                                st_next.kind = KIND_QUAD_READ;
                                st_next.dummy = DUMMY_QUAD_TAB[lat_code*4 +: 4];
                            end
                            OP_QUAD_IO_READ: begin
                                st_next.valid = quad_en;
                                st_next.kind = KIND_QUAD_READ;
                                st_next.mode = MODE_QUAD_CYC;
                                st_next.dummy = DUMMY_QUAD_TAB[lat_code*4 +: 4];
                            end
                            OP_DDR_QUAD_IO_READ: begin
                                st_next.valid = quad_en;
                                st_next.kind = KIND_DDR_READ;
                                st_next.mode = MODE_DDR_CYC;
                                st_next.dummy = DUMMY_DDR_TAB[lat_code*4 +: 4];
                            end
                            OP_QUAD_PAGE_PROGRAM: begin
                                if (quad_en && byte_ok && st_reg.wlat) begin
                                    st_next.valid = 1'b1;
                                    st_next.kind = KIND_WRITE;
                                    st_next.wlat = 1'b0;
                                end
                            end
                            OP_PAGE_PROGRAM,
                            OP_SECTOR_ERASE,
                            OP_BULK_ERASE,
                            OP_WRITE_REGISTERS: begin
                                if (byte_ok && st_reg.wlat) begin
                                    st_next.valid = 1'b1;
                                    st_next.kind = KIND_WRITE;
                                    st_next.wlat = 1'b0;
                                end
                            end
                            OP_WRITE_ENABLE: begin
                                st_next.valid = 1'b1;
                                st_next.kind = KIND_CONTROL;
                                st_next.wlat = 1'b1;
                            end
                            OP_WRITE_DISABLE: begin
                                st_next.valid = 1'b1;
                                st_next.kind = KIND_CONTROL;
                                st_next.wlat = 1'b0;
                            end
                            OP_DEEP_POWER_DOWN: begin
                                st_next.valid = 1'b1;
                                st_next.kind = KIND_CONTROL;
                                st_next.dpd = 1'b1;
                            end
                            OP_SOFT_RESET: begin
                                st_next.pwr = PWR_STARTUP;
                                st_next.cnt = '0;
                            end
                            default: begin
                                st_next.kind = KIND_NONE;
                            end
                        endcase
                    end
                end
            end
            default: begin
                st_next.pwr = PWR_OFF;
            end
        endcase
        // Hardware reset restarts initialisation from any powered state.
        if (!hwrst_n_s && pwr_s) begin
            st_next.pwr = PWR_STARTUP;
            st_next.cnt = '0;
            st_next.valid = 1'b0;
        end
        // Loss of supply overrides everything.
        if (!pwr_s) begin
            st_next.pwr = PWR_OFF;
            st_next.cnt = '0;
            st_next.valid = 1'b0;
            st_next.wlat = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_reg.pwr <= PWR_OFF;
            st_reg.cnt <= '0;
            st_reg.tog_seen <= 1'b0;
            st_reg.cfg1 <= CFG1_RESET;
            st_reg.wlat <= 1'b0;
            st_reg.dpd <= 1'b0;
            st_reg.valid <= 1'b0;
            st_reg.opc <= 8'h00;
            st_reg.kind <= KIND_NONE;
            st_reg.mode <= 4'h0;
            st_reg.dummy <= 4'h0;
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign ready = (st_reg.pwr == PWR_STANDBY);
    assign configuration_register_one = st_reg.cfg1;
    assign write_enable_latch = st_reg.wlat;
    assign deep_power_down = st_reg.dpd;
    assign cmd_valid = st_reg.valid;
    assign cmd_opcode = st_reg.opc;
    assign cmd_kind = st_reg.kind;
    assign cmd_mode_cycles = st_reg.mode;
    assign cmd_dummy_cycles = st_reg.dummy;

endmodule
`default_nettype wire

// file: design/sfcg_link.sv
// Serial clock domain: instruction capture and clock pulse counting.
`timescale 1ns/10ps
`default_nettype none
module sfcg_link
    import sfcg_pkg::*;
(
    // Link pins and reset
    input wire logic sck,
    input wire logic rst_n,
    input wire logic cs_n,
    input wire logic si,
    // Frame results, stable while chip select is high
    output logic [7:0] opcode,
    output logic opcode_full,
    output logic [2:0] pulse_mod,
    output logic frame_tog
);

    typedef struct packed {
        logic [7:0] opc;
        logic [3:0] nbits;
        logic [2:0] mod;
        logic tog;
    } sfcg_link_type;

    sfcg_link_type st_reg;
    sfcg_link_type st_next;
    logic fresh_reg;

    // Marks the first serial clock edge of a frame.
    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            fresh_reg <= 1'b1;
        end else begin
            fresh_reg <= 1'b0;
        end
    end

    always_comb begin
        st_next = st_reg;
        if (fresh_reg) begin
            st_next.opc = {7'h00, si};
            st_next.nbits = 4'h1;
            st_next.mod = 3'h1;
            st_next.tog = ~st_reg.tog;
        end else begin
            if (st_reg.nbits < INSTR_BITS_4) begin
                st_next.opc = {st_reg.opc[6:0], si};
                st_next.nbits = st_reg.nbits + 4'h1;
            end
            st_next.mod = st_reg.mod + 3'h1;
        end
    end

    always_ff @(posedge sck or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else if (!cs_n) begin
            st_reg <= st_next;
        end
    end

    assign opcode = st_reg.opc;
    assign opcode_full = (st_reg.nbits == INSTR_BITS_4);
    assign pulse_mod = st_reg.mod;
    assign frame_tog = st_reg.tog;

endmodule
`default_nettype wire

// file: design/sfcg_pkg.sv
// Shared constants and types of the serial flash command gate.
package sfcg_pkg;

    // ------------------------------------------------------------
    // Clock and power-up timing
    // ------------------------------------------------------------
    localparam int CLK_FREQ_MHZ = 125;
    localparam int POWER_UP_DELAY_US = 300;
    // Longest time, so the cycle count rounds down.
    localparam int POWER_UP_DELAY_CYC = (POWER_UP_DELAY_US * CLK_FREQ_MHZ * 1000) / 1000;

    // ------------------------------------------------------------
    // Configuration register one layout
    // ------------------------------------------------------------
    localparam int CFG1_LAT_MSB = 7;
    localparam int CFG1_LAT_LSB = 6;
    localparam int CFG1_QUAD_BIT = 1;
    localparam logic [7:0] CFG1_RESET = 8'h02;

    // ------------------------------------------------------------
    // Instruction framing
    // ------------------------------------------------------------
    localparam int INSTR_BITS = 8;
    localparam logic [3:0] INSTR_BITS_4 = 4'h8;
    localparam logic [2:0] BYTE_MOD_ZERO = 3'h0;

    // ------------------------------------------------------------
    // Instruction codes
    // ------------------------------------------------------------
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_FAST_READ = 8'h0B;
    localparam logic [7:0] OP_QUAD_OUT_READ = 8'h6B;
    localparam logic [7:0] OP_QUAD_IO_READ = 8'hEB;
    localparam logic [7:0] OP_DDR_QUAD_IO_READ = 8'hED;
    localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
    localparam logic [7:0] OP_QUAD_PAGE_PROGRAM = 8'h32;
    localparam logic [7:0] OP_SECTOR_ERASE = 8'hD8;
    localparam logic [7:0] OP_BULK_ERASE = 8'h60;
    localparam logic [7:0] OP_WRITE_REGISTERS = 8'h01;
    localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] OP_DEEP_POWER_DOWN = 8'hB9;
    localparam logic [7:0] OP_RELEASE_POWER_DOWN = 8'hAB;
    localparam logic [7:0] OP_SOFT_RESET = 8'hF0;

    // ------------------------------------------------------------
    // Latency tables, one nibble per latency code, code 0 lowest
    // ------------------------------------------------------------
    localparam logic [15:0] DUMMY_FAST_TAB = 16'h0888;
    localparam logic [15:0] DUMMY_QUAD_TAB = 16'h0548;
    localparam logic [15:0] DUMMY_DDR_TAB = 16'h8765;
    localparam logic [3:0] MODE_QUAD_CYC = 4'h2;
    localparam logic [3:0] MODE_DDR_CYC = 4'h1;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PWR_OFF,
        PWR_STARTUP,
        PWR_STANDBY
    } sfcg_pwr_type;

    typedef enum logic [2:0] {
        KIND_NONE,
        KIND_READ,
        KIND_QUAD_READ,
        KIND_DDR_READ,
        KIND_WRITE,
        KIND_CONTROL
    } sfcg_kind_type;

endpackage

// file: design/sfcg_sync.sv
// Three-stage synchroniser with agreement filter for pin inputs.
`timescale 1ns/10ps
`default_nettype none
module sfcg_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    // Clock and control
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // Data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] q;
    } sfcg_sync_type;

    sfcg_sync_type st_reg;
    sfcg_sync_type st_next;

    always_comb begin
        st_next = st_reg;
        st_next.s1 = async_in;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        for (int i = 0; i < WIDTH; i++) begin
            if (st_reg.s2[i] == st_reg.s3[i]) begin
                st_next.q[i] = st_reg.s3[i];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            st_reg <= {INIT, INIT, INIT, INIT};
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    assign sync_out = st_reg.q;

endmodule
`default_nettype wire

// file: verification/sfcg_gate_properties.sv
// Concurrent checks on the ports of the command gate.
`timescale 1ns/10ps
`default_nettype none
module sfcg_gate_properties
    import sfcg_pkg::*;
#(
    parameter int PU_CYCLES = sfcg_pkg::POWER_UP_DELAY_CYC
) (
    // Clock and pins
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic vcc_above_min,
    input wire logic vcc_above_cutoff,
    input wire logic hw_reset_n,
    // Status and command
    input wire logic ready,
    input wire logic [7:0] configuration_register_one,
    input wire logic write_enable_latch,
    input wire logic deep_power_down,
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_opcode,
    input wire sfcg_pkg::sfcg_kind_type cmd_kind,
    input wire logic [3:0] cmd_mode_cycles,
    input wire logic [3:0] cmd_dummy_cycles
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Counts clean supply cycles since the last power or reset event.
    int up_cnt;
    always_ff @(posedge clk) begin
        if (!rst_n || !vcc_above_min || !hw_reset_n) begin
            up_cnt <= 0;
        end else if (ce && up_cnt < PU_CYCLES + 17) begin
            up_cnt <= up_cnt + 1;
        end
    end
    property p_reset_state;
        $rose(rst_n) |-> configuration_register_one == CFG1_RESET && !ready;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("bad reset state");
    property p_valid_ready;
        cmd_valid |-> ready;
    endproperty
    a_valid_ready: assert property (p_valid_ready) else $error("command before ready");
    property p_ready_early;
        $rose(ready) |-> up_cnt >= PU_CYCLES;
    endproperty
    a_ready_early: assert property (p_ready_early) else $error("ready too early");
    property p_ready_late;
        up_cnt == PU_CYCLES + 16 |-> ready;
    endproperty
    a_ready_late: assert property (p_ready_late) else $error("ready too late");
    property p_cutoff;
        (!vcc_above_cutoff)[*8] |-> !cmd_valid;
    endproperty
    a_cutoff: assert property (p_cutoff) else $error("command below cut-off");
    property p_off;
        (!vcc_above_min)[*8] |-> !cmd_valid && !ready;
    endproperty
    a_off: assert property (p_off) else $error("activity while off");
    property p_hw_reset;
        (!hw_reset_n)[*8] |-> !ready && !cmd_valid;
    endproperty
    a_hw_reset: assert property (p_hw_reset) else $error("ready in reset");
    property p_quad;
        cmd_valid && (cmd_kind == KIND_QUAD_READ || cmd_opcode == OP_QUAD_PAGE_PROGRAM)
            |-> configuration_register_one[CFG1_QUAD_BIT];
    endproperty
    a_quad: assert property (p_quad) else $error("quad without enable");
    property p_ddr;
        cmd_valid && cmd_kind == KIND_DDR_READ |-> configuration_register_one[CFG1_QUAD_BIT];
    endproperty
    a_ddr: assert property (p_ddr) else $error("ddr without enable");
    property p_latency;
        cmd_valid && cmd_opcode == OP_QUAD_IO_READ |-> cmd_mode_cycles == MODE_QUAD_CYC
            && cmd_dummy_cycles == DUMMY_QUAD_TAB[configuration_register_one[7:6]*4 +: 4];
    endproperty
    a_latency: assert property (p_latency) else $error("wrong latency");
    property p_pu_clear;
        $rose(ready) |-> !write_enable_latch && !deep_power_down;
    endproperty
    a_pu_clear: assert property (p_pu_clear) else $error("state after power-up");
    cover property (cmd_valid && cmd_kind == KIND_WRITE);
    cover property (cmd_valid && cmd_kind == KIND_DDR_READ);
    cover property ($rose(ready));
endmodule
bind sfcg_gate sfcg_gate_properties #(.PU_CYCLES(PU_CYCLES)) u_props (
    .clk(clk), .rst_n(rst_n), .ce(ce), .vcc_above_min(vcc_above_min),
    .vcc_above_cutoff(vcc_above_cutoff), .hw_reset_n(hw_reset_n), .ready(ready),
    .configuration_register_one(configuration_register_one),
    .write_enable_latch(write_enable_latch), .deep_power_down(deep_power_down),
    .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode), .cmd_kind(cmd_kind),
    .cmd_mode_cycles(cmd_mode_cycles), .cmd_dummy_cycles(cmd_dummy_cycles)
);
`default_nettype wire

// file: verification/sfcg_host.sv
// Host controller model that drives chip select, serial clock and data.
`timescale 1ns/10ps
`default_nettype none
module sfcg_host (
    // Link pins
    output var logic sck,
    output var logic cs_n,
    output var logic si
);
    // ------------------------------------------------------------
    // Frames
    // ------------------------------------------------------------
    // Select stays high and the clock still until a frame is asked for.
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        si = 1'b1;
    end
    // Sends n bits, most significant first, then releases select.
    task automatic frame(input logic [15:0] bits, input int n);
        cs_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            si = bits[15-i];
            #5 sck = 1'b1;
            #6 sck = 1'b0;
            #1;
        end
        #3 cs_n = 1'b1;
        si = ~si;
    endtask
endmodule
`default_nettype wire

// file: verification/tb_top.sv
// Self-checking bench of the serial flash command gate.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import sfcg_pkg::*;
    localparam int PU = 40;
    logic clk, rst_n, ce, sck, cs_n, si, vcc_above_min, vcc_above_cutoff, hw_reset_n;
    logic cfg_wr, ready, write_enable_latch, deep_power_down, cmd_valid;
    logic [7:0] cfg_data, configuration_register_one, cmd_opcode;
    logic [3:0] cmd_mode_cycles, cmd_dummy_cycles;
    sfcg_kind_type cmd_kind;
    logic [7:0] wr_ops [4] = '{OP_PAGE_PROGRAM, OP_SECTOR_ERASE, OP_BULK_ERASE, OP_WRITE_REGISTERS};
    logic [7:0] q_ops [4] = '{OP_QUAD_OUT_READ, OP_QUAD_IO_READ, OP_DDR_QUAD_IO_READ,
        OP_QUAD_PAGE_PROGRAM};
    int error_cnt = 0;
    int checks_done = 0;
    int n;
    // ------------------------------------------------------------
    // Design, host and tasks
    // ------------------------------------------------------------
    sfcg_gate #(.PU_CYCLES(PU)) uut (
        .clk(clk), .rst_n(rst_n), .ce(ce), .sck(sck), .cs_n(cs_n), .si(si),
        .vcc_above_min(vcc_above_min), .vcc_above_cutoff(vcc_above_cutoff),
        .hw_reset_n(hw_reset_n), .cfg_wr(cfg_wr), .cfg_data(cfg_data), .ready(ready),
        .configuration_register_one(configuration_register_one),
        .write_enable_latch(write_enable_latch), .deep_power_down(deep_power_down),
        .cmd_valid(cmd_valid), .cmd_opcode(cmd_opcode), .cmd_kind(cmd_kind),
        .cmd_mode_cycles(cmd_mode_cycles), .cmd_dummy_cycles(cmd_dummy_cycles)
    );
    sfcg_host host (.sck(sck), .cs_n(cs_n), .si(si));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic give_verdict();
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1) begin
            error_cnt++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask
    task automatic wait_ready();
        n = 0;
        while (ready !== 1'b1) begin
            @(negedge clk);
            n++;
            if (n > 200) begin
                check(1'b0, "ready never came");
                give_verdict();
            end
        end
    endtask
    // Sends one frame and watches sixteen cycles for an accepted command.
    task automatic cmd(input logic [7:0] op, input int bits, input logic exp);
        logic got;
        got = 1'b0;
        host.frame({op, 8'h00}, bits);
        repeat (16) begin
            @(posedge clk);
            #1;
            if (cmd_valid === 1'b1) begin
                got = 1'b1;
            end
        end
        check(got === exp && (!exp || cmd_opcode === op), "command acceptance");
        @(negedge clk);
    endtask
    task automatic cfg(input logic [7:0] d);
        cfg_wr = 1'b1;
        cfg_data = d;
        @(negedge clk);
        cfg_wr = 1'b0;
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        vcc_above_min = 1'b1;
        vcc_above_cutoff = 1'b1;
        hw_reset_n = 1'b1;
        cfg_wr = 1'b0;
        cfg_data = 8'h00;
        repeat (20) @(negedge clk);
        check(configuration_register_one === CFG1_RESET, "config reset");
        rst_n = 1'b1;
        wait_ready();
        check(n >= PU, "delay short");
        check(write_enable_latch === 1'b0 && deep_power_down === 1'b0, "idle");
        foreach (wr_ops[i]) begin
            cmd(OP_WRITE_ENABLE, 8, 1'b1);
            cmd(wr_ops[i], 15, 1'b0);
            check(write_enable_latch === 1'b1, "latch lost");
            cmd(wr_ops[i], 16, 1'b1);
            check(cmd_kind === KIND_WRITE, "write kind");
        end
        for (int c = 0; c < 4; c++) begin
            cfg({c[1:0], 6'h02});
            cmd(OP_QUAD_IO_READ, 8, 1'b1);
            check(cmd_dummy_cycles === DUMMY_QUAD_TAB[c*4 +: 4], "quad latency");
            cmd(OP_DDR_QUAD_IO_READ, 8, 1'b1);
            check(cmd_dummy_cycles === DUMMY_DDR_TAB[c*4 +: 4], "ddr latency");
            check(cmd_mode_cycles === MODE_DDR_CYC, "ddr mode");
        end
        cmd(OP_WRITE_ENABLE, 8, 1'b1);
        cfg(8'h00);
        foreach (q_ops[i]) begin
            cmd(q_ops[i], 16, 1'b0);
        end
        cfg(CFG1_RESET);
        cmd(OP_QUAD_PAGE_PROGRAM, 16, 1'b1);
        cmd(OP_FAST_READ, 8, 1'b1);
        check(cmd_dummy_cycles === DUMMY_FAST_TAB[3:0], "fast latency");
        cmd(OP_DEEP_POWER_DOWN, 8, 1'b1);
        check(deep_power_down === 1'b1, "power-down entry");
        cmd(OP_WRITE_ENABLE, 8, 1'b0);
        cmd(OP_RELEASE_POWER_DOWN, 8, 1'b0);
        check(deep_power_down === 1'b0, "power-down release");
        cmd(OP_WRITE_ENABLE, 8, 1'b1);
        vcc_above_cutoff = 1'b0;
        repeat (8) @(negedge clk);
        cmd(OP_SECTOR_ERASE, 16, 1'b0);
        vcc_above_cutoff = 1'b1;
        vcc_above_min = 1'b0;
        repeat (8) @(negedge clk);
        check(ready === 1'b0 && write_enable_latch === 1'b0, "off state");
        cmd(OP_WRITE_ENABLE, 8, 1'b0);
        cfg(8'h40);
        check(configuration_register_one === CFG1_RESET, "config while off");
        vcc_above_min = 1'b1;
        wait_ready();
        check(n >= PU, "delay short");
        hw_reset_n = 1'b0;
        repeat (10) @(negedge clk);
        check(ready === 1'b0, "hardware reset");
        hw_reset_n = 1'b1;
        cmd(OP_WRITE_ENABLE, 8, 1'b0);
        wait_ready();
        cmd(OP_SOFT_RESET, 8, 1'b0);
        check(ready === 1'b0, "soft reset");
        wait_ready();
        give_verdict();
    end
endmodule
`default_nettype wire
